// ---- rtl/hdv_pkg.sv ----
// Constants, types and field layouts of the video deformatter output stage
// Operation
// - Chroma CRC mismatch flag high on disagreement
// - Luma CRC mismatch flag high on disagreement
// - FIFO load strobe low one EAV/SAV word
// - Output buses driven while enable_n low
// - Chroma word on output bits 9..0
// - Luma word on output bits 19..10
// - Line fault on bad or flywheel-mismatched number
// - One bad line number faults two lines
// - Start reference fault on bad SAV
// - End reference fault on bad EAV
// - Everything except the output bus enable sampled on rising clock edge
// - Reference faults on flywheel HVF disagreement
package hdv_pkg;
  // ==========================================================
  // Stream layout
  localparam int          CH_W       = 10;
  localparam int          BUS_W      = 20;
  localparam int          LUMA_LSB   = 10;
  localparam int          CHROMA_LSB = 0;
  localparam int          PIPE_DEPTH = 4;
  localparam logic [9:0]  TRS_ONES   = 10'h3FF;
  localparam logic [9:0]  TRS_ZERO   = 10'h000;
  localparam int          XYZ_ONE    = 9;
  localparam int          XYZ_F      = 8;
  localparam int          XYZ_V      = 7;
  localparam int          XYZ_H      = 6;
  localparam int          XYZ_P3     = 5;
  localparam int          XYZ_P2     = 4;
  localparam int          XYZ_P1     = 3;
  localparam int          XYZ_P0     = 2;
  localparam int          LN_W       = 11;
  localparam logic [10:0] LN_FIRST   = 11'h001;
  localparam logic [10:0] LN_STEP    = 11'h001;
  // ==========================================================
  // Line CRC
  localparam int          CRC_W      = 18;
  localparam int          CRC_HALF   = 9;
  localparam int          CRC_TAP_A  = 13;
  localparam int          CRC_TAP_B  = 12;
  localparam logic [17:0] CRC_INIT   = 18'h00000;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_STATUS = 8'h04;
  localparam logic [7:0]  OFS_ISTAT  = 8'h08;
  localparam logic [7:0]  OFS_IMASK  = 8'h0C;
  localparam logic [7:0]  OFS_LINE   = 8'h10;
  localparam int          CTRL_SEL   = 0;
  localparam int          NFLAG      = 5;
  localparam logic [4:0]  FLAGS_RST  = 5'h00;
  localparam logic        CTRL_RST   = 1'b0;
  // ==========================================================
  // Types
  typedef struct packed {
    logic eav;
    logic sav;
    logic ln;
    logic chroma;
    logic luma;
  } hdv_flags_t;
  typedef struct packed {
    logic        en;
    logic        f;
    logic        v;
    logic        h;
    logic [10:0] line;
  } hdv_fly_t;
  typedef enum logic [4:0] {
    POST_IDLE = 5'b00001,
    POST_LN0  = 5'b00010,
    POST_LN1  = 5'b00100,
    POST_CRC0 = 5'b01000,
    POST_CRC1 = 5'b10000
  } hdv_post_t;
endpackage

// ---- rtl/hdv_crc.sv ----
// Line CRC accumulator for one 10-bit channel
`timescale 1ns/1ps
`default_nettype none
module hdv_crc #(
  parameter int DW = 10
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      ce_i,
  input  wire logic                      init_i,
  input  wire logic                      en_i,
  input  wire logic [DW-1:0]             din_i,
  output logic      [hdv_pkg::CRC_W-1:0] crc_o
);
  import hdv_pkg::*;
  logic [CRC_W-1:0] crc_q;
  logic [CRC_W-1:0] crc_d;
  logic [CRC_W-1:0] step;
  logic             fb;

  if (DW < 1) begin : g_bad_dw
    $error("hdv_crc: DW must be positive");
  end

  // Bit-serial LFSR, LSB first, one word per cycle
  always_comb begin
    step = crc_q;
    fb   = 1'b0;
    for (int i = 0; i < DW; i++) begin
      fb              = step[0] ^ din_i[i];
      step            = {fb, step[CRC_W-1:1]};
      step[CRC_TAP_A] = step[CRC_TAP_A] ^ fb;
      step[CRC_TAP_B] = step[CRC_TAP_B] ^ fb;
    end
    crc_d = crc_q;
    if (init_i) begin
      crc_d = CRC_INIT;
    end else if (en_i) begin
      crc_d = step;
    end
  end

  // Register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      crc_q <= CRC_INIT;
    end else if (ce_i) begin
      crc_q <= crc_d;
    end
  end

  assign crc_o = crc_q;
endmodule
`default_nettype wire

// ---- rtl/hdv_trs_check.sv ----
// Timing reference word check against protection bits and flywheel
`timescale 1ns/1ps
`default_nettype none
module hdv_trs_check (
  input  wire logic                 [9:0] xyz_i,
  input  wire hdv_pkg::hdv_fly_t          fly_i,
  output logic                            fault_o
);
  import hdv_pkg::*;
  logic prot_bad;
  logic fly_bad;

  // Protection bits and flywheel HVF comparison
  always_comb begin
    prot_bad = !xyz_i[XYZ_ONE]
             | (xyz_i[XYZ_P3] != (xyz_i[XYZ_V] ^ xyz_i[XYZ_H]))
             | (xyz_i[XYZ_P2] != (xyz_i[XYZ_F] ^ xyz_i[XYZ_H]))
             | (xyz_i[XYZ_P1] != (xyz_i[XYZ_F] ^ xyz_i[XYZ_V]))
             | (xyz_i[XYZ_P0] != (xyz_i[XYZ_F] ^ xyz_i[XYZ_V] ^ xyz_i[XYZ_H]));
    fly_bad  = fly_i.en
             & ({xyz_i[XYZ_F], xyz_i[XYZ_V], xyz_i[XYZ_H]} != {fly_i.f, fly_i.v, fly_i.h});
    fault_o  = prot_bad | fly_bad;
  end
endmodule
`default_nettype wire

// ---- rtl/hdv_status_out.sv ----
// Output and status stage: TRS decode, line checks, CRC compare, APB regs
`timescale 1ns/1ps
`default_nettype none
module hdv_status_out #(
  parameter int ADDR_W = 8
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      ce_i,
  input  wire logic [hdv_pkg::BUS_W-1:0] word_i,
  input  wire hdv_pkg::hdv_fly_t         fly_i,
  input  wire logic                      output_drive_enable_n_i,
  output logic      [hdv_pkg::BUS_W-1:0] data_out_o,
  output logic                           data_oe_o,
  output logic                           fifo_load_strobe_n_o,
  output logic                           luma_crc_mismatch_o,
  output logic                           chroma_crc_mismatch_o,
  output logic                           line_number_fault_o,
  output logic                           start_ref_fault_o,
  output logic                           end_ref_fault_o,
  output logic                           irq_o,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [ADDR_W-1:0]         paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic      [31:0]               prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o
);
  import hdv_pkg::*;

  if (ADDR_W < 5) begin : g_bad_addr
    $error("hdv_status_out: ADDR_W too small for register map");
  end

  // ==========================================================
  // Declarations
  logic [BUS_W-1:0] pipe_q [PIPE_DEPTH];
  logic [BUS_W-1:0] pipe_d [PIPE_DEPTH];
  logic [BUS_W-1:0] out_q, out_d;
  logic             fifo_n_q, fifo_n_d;
  hdv_post_t        post_q, post_d;
  logic             run_q, run_d;
  logic [6:0]       ln_lo_q, ln_lo_d;
  logic [LN_W-1:0]  ln_last_q, ln_last_d;
  logic [CRC_HALF-1:0] emb_l_q, emb_l_d, emb_c_q, emb_c_d;
  hdv_flags_t       flg_q, flg_d, ev;
  hdv_flags_t       istat_q, istat_d, imask_q, imask_d;
  logic             sel_q, sel_d;
  logic             irq_q, irq_d;
  logic [31:0]      rdata_q, rdata_d;
  logic             ready_q, ready_d;
  logic             err_q, err_d;
  logic [9:0]       y0, y1, y2, y3, c0;
  logic             hit, is_eav, ref_bad, ln_bad;
  logic [LN_W-1:0]  ln_now;
  logic             crc_init, crc_en;
  logic [CRC_W-1:0] crc_l, crc_c;
  logic             wr_acc, rd_acc;
  logic [7:0]       addr8;

  // ==========================================================
  // Channel views of the pipeline
  assign y0     = pipe_q[0][LUMA_LSB +: CH_W];
  assign y1     = pipe_q[1][LUMA_LSB +: CH_W];
  assign y2     = pipe_q[2][LUMA_LSB +: CH_W];
  assign y3     = pipe_q[3][LUMA_LSB +: CH_W];
  assign c0     = pipe_q[0][CHROMA_LSB +: CH_W];
  // TRS found when its first word sits at the pipe end
  assign hit    = (y3 == TRS_ONES) && (y2 == TRS_ZERO) && (y1 == TRS_ZERO) && y0[XYZ_ONE];
  assign is_eav = y0[XYZ_H];
  assign ln_now = {y0[5:2], ln_lo_q};

  // Reference word checker
  hdv_trs_check u_trs (
    .xyz_i   (y0),
    .fly_i   (fly_i),
    .fault_o (ref_bad)
  );

  // Line number continuity and flywheel comparison
  assign ln_bad = ((ln_now != ln_last_q + LN_STEP) && (ln_now != LN_FIRST))
                || (fly_i.en && (ln_now != fly_i.line));

  // CRC spans active words, EAV and both line number words
  assign crc_init = hit && !is_eav;
  assign crc_en   = run_q || (post_q == POST_LN0) || (post_q == POST_LN1);

  hdv_crc #(.DW(CH_W)) u_crc_luma (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .init_i    (crc_init),
    .en_i      (crc_en),
    .din_i     (y0),
    .crc_o     (crc_l)
  );
  hdv_crc #(.DW(CH_W)) u_crc_chroma (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .init_i    (crc_init),
    .en_i      (crc_en),
    .din_i     (c0),
    .crc_o     (crc_c)
  );

  // ==========================================================
  // Data path: delay line and output word
  always_comb begin
    pipe_d[0] = word_i;
    for (int i = 1; i < PIPE_DEPTH; i++) begin
      pipe_d[i] = pipe_q[i-1];
    end
    out_d    = pipe_q[PIPE_DEPTH-1];
    // Low while the first word of the chosen TRS goes out
    fifo_n_d = !(hit && (is_eav != sel_q));
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_q[i] <= '0;
      end
      out_q    <= '0;
      fifo_n_q <= 1'b1;
    end else if (ce_i) begin
      pipe_q   <= pipe_d;
      out_q    <= out_d;
      fifo_n_q <= fifo_n_d;
    end
  end

  // ==========================================================
  // Post-EAV word sequencer and status flags
  always_comb begin
    post_d    = post_q;
    run_d     = run_q;
    ln_lo_d   = ln_lo_q;
    ln_last_d = ln_last_q;
    emb_l_d   = emb_l_q;
    emb_c_d   = emb_c_q;
    flg_d     = flg_q;
    ev        = FLAGS_RST;
    if (hit) begin
      run_d = !is_eav;
      if (is_eav) begin
        flg_d.eav = ref_bad;
        ev.eav    = ref_bad;
      end else begin
        flg_d.sav = ref_bad;
        ev.sav    = ref_bad;
      end
    end
    case (post_q)
      POST_IDLE: begin
        if (hit && is_eav) begin
          post_d = POST_LN0;
        end
      end
      POST_LN0: begin
        ln_lo_d = y0[8:2];
        post_d  = POST_LN1;
      end
      POST_LN1: begin
        // Last number always kept, so one bad number faults two lines
        ln_last_d = ln_now;
        flg_d.ln  = ln_bad;
        ev.ln     = ln_bad;
        post_d    = POST_CRC0;
      end
      POST_CRC0: begin
        emb_l_d = y0[CRC_HALF-1:0];
        emb_c_d = c0[CRC_HALF-1:0];
        post_d  = POST_CRC1;
      end
      POST_CRC1: begin
        // One comparison per line, held until the next
        flg_d.luma   = crc_l != {y0[CRC_HALF-1:0], emb_l_q};
        flg_d.chroma = crc_c != {c0[CRC_HALF-1:0], emb_c_q};
        ev.luma      = flg_d.luma;
        ev.chroma    = flg_d.chroma;
        post_d       = POST_IDLE;
      end
      default: begin
        post_d = POST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      post_q    <= POST_IDLE;
      run_q     <= 1'b0;
      ln_lo_q   <= '0;
      ln_last_q <= '0;
      emb_l_q   <= '0;
      emb_c_q   <= '0;
      flg_q     <= FLAGS_RST;
    end else if (ce_i) begin
      post_q    <= post_d;
      run_q     <= run_d;
      ln_lo_q   <= ln_lo_d;
      ln_last_q <= ln_last_d;
      emb_l_q   <= emb_l_d;
      emb_c_q   <= emb_c_d;
      flg_q     <= flg_d;
    end
  end

  // ==========================================================
  // APB slave, one wait state; interrupt status and mask
  assign addr8  = 8'(paddr_i);
  assign wr_acc = psel_i && penable_i && ready_q && pwrite_i;
  assign rd_acc = psel_i && penable_i && !ready_q && !pwrite_i;

  always_comb begin
    ready_d = psel_i && penable_i && !ready_q;
    err_d   = 1'b0;
    rdata_d = '0;
    sel_d   = sel_q;
    imask_d = imask_q;
    istat_d = istat_q;
    if (ready_d) begin
      case (addr8)
        OFS_CTRL:   rdata_d = 32'(sel_q);
        OFS_STATUS: rdata_d = 32'(flg_q);
        OFS_ISTAT:  rdata_d = 32'(istat_q);
        OFS_IMASK:  rdata_d = 32'(imask_q);
        OFS_LINE:   rdata_d = 32'(ln_last_q);
        default:    err_d   = 1'b1;
      endcase
    end
    if (!rd_acc) begin
      rdata_d = rdata_d & {32{ready_d}};
    end
    if (wr_acc) begin
      case (addr8)
        OFS_CTRL:  sel_d   = pwdata_i[CTRL_SEL];
        OFS_IMASK: imask_d = pwdata_i[NFLAG-1:0];
        OFS_ISTAT: istat_d = istat_q & ~pwdata_i[NFLAG-1:0];
        default:   sel_d   = sel_q;
      endcase
    end
    // New events win over a same-cycle clear
    istat_d = istat_d | ev;
    irq_d   = |(istat_d & imask_d);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ready_q <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= '0;
      sel_q   <= CTRL_RST;
      imask_q <= FLAGS_RST;
      istat_q <= FLAGS_RST;
      irq_q   <= 1'b0;
    end else if (ce_i) begin
      ready_q <= ready_d;
      err_q   <= err_d;
      rdata_q <= rdata_d;
      sel_q   <= sel_d;
      imask_q <= imask_d;
      istat_q <= istat_d;
      irq_q   <= irq_d;
    end
  end

  // ==========================================================
  // Outputs; bus enable follows its pin without the clock
  assign data_out_o            = out_q;
  assign data_oe_o             = !output_drive_enable_n_i;
  assign fifo_load_strobe_n_o  = fifo_n_q;
  assign luma_crc_mismatch_o   = flg_q.luma;
  assign chroma_crc_mismatch_o = flg_q.chroma;
  assign line_number_fault_o   = flg_q.ln;
  assign start_ref_fault_o     = flg_q.sav;
  assign end_ref_fault_o       = flg_q.eav;
  assign irq_o                 = irq_q;
  assign prdata_o              = rdata_q;
  assign pready_o              = ready_q;
  assign pslverr_o             = err_q;

  // ==========================================================
  // Assertions
  sequence s_ce5;
    (ce_i && rst_n_i) [*5];
  endsequence

  a_strobe_on_trs: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && hit && (is_eav != sel_q) |=> !fifo_load_strobe_n_o)
    else $error("strobe not low on selected TRS");
  a_strobe_one_word: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !fifo_load_strobe_n_o && ce_i |=> fifo_load_strobe_n_o)
    else $error("strobe low longer than one word");
  a_chroma_lane: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_ce5 |=> data_out_o[9:0] == $past(word_i[9:0], 5))
    else $error("chroma lane wrong");
  a_luma_lane: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_ce5 |=> data_out_o[19:10] == $past(word_i[19:10], 5))
    else $error("luma lane wrong");
  a_ln_fault_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && post_q == POST_LN1 |=> line_number_fault_o == $past(ln_bad))
    else $error("line fault not updated");
  a_ln_fault_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !(ce_i && post_q == POST_LN1) |=> $stable(line_number_fault_o))
    else $error("line fault changed between lines");
  a_sav_fault: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && hit && !is_eav |=> start_ref_fault_o == $past(ref_bad))
    else $error("start reference fault wrong");
  a_eav_fault: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && hit && is_eav |=> end_ref_fault_o == $past(ref_bad))
    else $error("end reference fault wrong");
  a_luma_crc_cmp: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && post_q == POST_CRC1 |=>
      luma_crc_mismatch_o == ($past(crc_l) != {$past(y0[8:0]), $past(emb_l_q)}))
    else $error("luma CRC flag wrong");
  a_chroma_crc_cmp: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && post_q == POST_CRC1 |=>
      chroma_crc_mismatch_o == ($past(crc_c) != {$past(c0[8:0]), $past(emb_c_q)}))
    else $error("chroma CRC flag wrong");
  a_crc_flag_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !(ce_i && post_q == POST_CRC1) |=> $stable(luma_crc_mismatch_o) && $stable(chroma_crc_mismatch_o))
    else $error("CRC flag changed mid line");
endmodule
`default_nettype wire

// ---- test/hdv_video_src.sv ----
// Upstream receiver model: aligned lines with TRS, line number and CRC words
`timescale 1ns/1ps
`default_nettype none
module hdv_video_src (
  input  wire logic                      ref_clk_i,
  output var  logic [hdv_pkg::BUS_W-1:0] word_o,
  output var  hdv_pkg::hdv_fly_t         fly_o,
  output var  logic [1:0]                tag_o
);
  import hdv_pkg::*;
  logic [17:0] cy;
  logic [17:0] cc;
  logic        acc;
  // ==========================================================
  // Word builders
  function automatic logic [17:0] crc10(input logic [17:0] c, input logic [9:0] d);
    logic fb;
    for (int i = 0; i < 10; i++) begin
      fb = c[0] ^ d[i];
      c = {fb, c[17:1]};
      c[13] = c[13] ^ fb;
      c[12] = c[12] ^ fb;
    end
    return c;
  endfunction
  function automatic logic [9:0] xyz(input logic f, v, h, bad);
    return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00} ^ {7'h00, bad, 2'b00};
  endfunction
  // Idle blanking at time zero
  initial begin
    word_o = {10'h040, 10'h200};
    tag_o = 2'd0;
    fly_o = '0;
    acc = 1'b0;
  end
  // ==========================================================
  // Emit one word just after a rising edge
  task automatic put(input logic [9:0] y, input logic [9:0] c, input logic [1:0] t);
    @(posedge ref_clk_i);
    word_o <= {y, c};
    tag_o <= t;
    if (acc) begin
      cy = crc10(cy, y);
      cc = crc10(cc, c);
    end
  endtask
  // One line: SAV, active, EAV, line number, CRC, blanking
  task automatic send_line(input logic [10:0] ln, input logic [10:0] fln, input logic fen,
                           input logic f, v, input logic [1:0] sb, eb, cb);
    logic [9:0] w;
    fly_o <= '{en: fen, f: f, v: v, h: sb == 2'd2, line: fln};
    put(TRS_ONES, TRS_ONES, 2'd2);
    repeat (2) put(TRS_ZERO, TRS_ZERO, 2'd0);
    w = xyz(f, v, 1'b0, sb == 2'd1);
    put(w, w, 2'd0);
    cy = CRC_INIT;
    cc = CRC_INIT;
    acc = 1'b1;
    for (int i = 0; i < 8; i++) begin
      w = 10'h040 + {1'b0, ln[5:0], i[2:0]};
      put(w, w + 10'h100, 2'd0);
    end
    fly_o.h <= eb != 2'd2;
    put(TRS_ONES, TRS_ONES, 2'd1);
    repeat (2) put(TRS_ZERO, TRS_ZERO, 2'd0);
    w = xyz(f, v, 1'b1, eb == 2'd1);
    put(w, w, 2'd0);
    w = {~ln[6], ln[6:0], 2'b00};
    put(w, w, 2'd0);
    w = {4'h8, ln[10:7], 2'b00};
    put(w, w, 2'd0);
    acc = 1'b0;
    put({~cy[8], cy[8:0]} ^ {7'h00, cb[0], 2'b00}, {~cc[8], cc[8:0]} ^ {7'h00, cb[1], 2'b00}, 2'd0);
    put({~cy[17], cy[17:9]}, {~cc[17], cc[17:9]}, 2'd0);
    repeat (8) put(10'h040, 10'h200, 2'd0);
  endtask
endmodule
`default_nettype wire

// ---- test/hdv_status_out_tb_top.sv ----
// Self-checking bench for the deformatter output and status stage
`timescale 1ns/1ps
`default_nettype none
module hdv_status_out_tb_top;
  import hdv_pkg::*;
  logic             ref_clk_i = 1'b0;
  logic             rst_n_i = 1'b0;
  logic             oe_n = 1'b0;
  logic             ce = 1'b1;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata;
  logic             pready, pslverr, irq, doe, stb_n, sel = 1'b0;
  logic [BUS_W-1:0] word, dout;
  logic [4:0][19:0] hw = '0;
  logic [4:0][1:0]  ht = '0;
  logic [31:0]      r, rr;
  hdv_fly_t         fly;
  wire hdv_flags_t  fl;
  hdv_flags_t       ex;
  int               seed = 21, cyc = 0, hcnt = 0, fail_count = 0, checks = 0;
  logic [1:0]       tag;
  hdv_video_src u_src (.ref_clk_i(ref_clk_i), .word_o(word), .fly_o(fly), .tag_o(tag));
  hdv_status_out #(.ADDR_W(8)) DUT (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .word_i(word), .fly_i(fly),
    .output_drive_enable_n_i(oe_n), .data_out_o(dout), .data_oe_o(doe),
    .fifo_load_strobe_n_o(stb_n), .luma_crc_mismatch_o(fl.luma),
    .chroma_crc_mismatch_o(fl.chroma), .line_number_fault_o(fl.ln),
    .start_ref_fault_o(fl.sav), .end_ref_fault_o(fl.eav), .irq_o(irq),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
  // ==========================================================
  // Clock and timeout
  always #2 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 12000) begin
      fail_count++;
      end_sim();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x,
                     input logic xe);
    logic [31:0] d;
    logic        e;
    apb(1'b0, a, 32'h0, d, e);
    chk(nm, x, d);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    chk("pslverr", 32'h0, {31'h0, e});
  endtask
  task automatic end_sim();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Pipeline model: word and strobe appear five edges after sampling
  always @(posedge ref_clk_i) begin
    chk("data_oe", {31'h0, ~oe_n}, {31'h0, doe});
    if (rst_n_i && hcnt >= 5) begin
      chk("data_out", {12'h0, hw[4]}, {12'h0, dout});
      chk("strobe_n", {31'h0, ht[4] != (sel ? 2'd2 : 2'd1)}, {31'h0, stb_n});
    end
    // Model advances only on edges where the block is enabled
    hcnt <= !rst_n_i ? 0 : (ce ? hcnt + 1 : hcnt);
    if (ce) begin
      hw <= {hw[3:0], word};
      ht <= {ht[3:0], tag};
    end
    rr = $random(seed);
    oe_n <= rr[0];
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [10:0] ln, lnx, fln, last;
    logic [4:0]  ist, clr, msk;
    ln = 11'd1;
    last = 11'd0;
    ist = 5'h00;
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk("reset_out", 32'h1, {11'h0, dout, stb_n});
    chk("reset_flags", 32'h0, {26'h0, fl, irq});
    rdc("ctrl", OFS_CTRL, 32'h0, 1'b0);
    rdc("imask", OFS_IMASK, 32'h0, 1'b0);
    rdc("istat", OFS_ISTAT, 32'h0, 1'b0);
    for (int n = 0; n < 40; n++) begin
      r = $random(seed);
      wr(OFS_CTRL, {31'h0, r[0]});
      sel = r[0];
      lnx = (r[12:10] == 3'd0) ? ln + 11'd7 : ln;
      fln = (r[15:13] == 3'd0) ? lnx + 11'd1 : lnx;
      u_src.send_line(lnx, fln, r[1], r[2], r[3], r[5:4], r[7:6], r[9:8]);
      ex.luma = r[8];
      ex.chroma = r[9];
      ex.ln = (lnx != last + 11'd1 && lnx != LN_FIRST) || (r[1] && lnx != fln);
      ex.sav = r[5:4] == 2'd1 || (r[5:4] == 2'd2 && r[1]);
      ex.eav = r[7:6] == 2'd1 || (r[7:6] == 2'd2 && r[1]);
      chk("flags", {27'h0, ex}, {27'h0, fl});
      rdc("status", OFS_STATUS, {27'h0, ex}, 1'b0);
      rdc("line", OFS_LINE, {21'h0, lnx}, 1'b0);
      ist = ist | ex;
      rdc("istat", OFS_ISTAT, {27'h0, ist}, 1'b0);
      clr = r[20:16];
      msk = r[25:21];
      wr(OFS_ISTAT, {27'h0, clr});
      ist = ist & ~clr;
      // Freeze in the idle gap; the mask write must stall until enabled
      ce <= 1'b0;
      fork
        wr(OFS_IMASK, {27'h0, msk});
        begin
          repeat (3) @(posedge ref_clk_i);
          ce <= 1'b1;
        end
      join
      repeat (2) @(posedge ref_clk_i);
      chk("irq", {31'h0, |(ist & msk)}, {31'h0, irq});
      last = lnx;
      ln = ln + 11'd1;
    end
    rdc("ctrl", OFS_CTRL, {31'h0, sel}, 1'b0);
    wr(OFS_STATUS, 32'h1F);
    rdc("status_ro", OFS_STATUS, {27'h0, ex}, 1'b0);
    rdc("unmapped", 8'h14, 32'h0, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
